/* File: logic/pbist_top.sv */
// Chosen here: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// [R01] checker counts every received test byte in a 16-bit total
// [R02] with saturation mode zero the byte total stops at 0xFFFF
// [R03] software sees a byte total frozen by a lock or lock-and-clear write
// [R04] checker counts mismatching bytes in an 8-bit total
// [R05] with saturation mode zero the error total stops at 0xFF
// [R06] writing status bit 0 pulses a lock that snapshots the byte and error totals
// [R07] writing status bit 1 locks, then clears counters and both overflow flags
// [R08] status bit 10 flags packet counter overflow until counters are cleared
// [R09] status bit 9 flags byte counter overflow until counters are cleared
// [R10] every generated payload is exactly the 16-bit length setting, reset 1500
// [R11] each frame starts with thirteen 0x5 nibbles then delimiter 0xD5
// [R12] frames are separated by four idle bytes per gap step, reset 0x7D; a zero setting still leaves one idle nibble
// [R13] software locks before reading so both counts come from one snapshot
// [R14] with saturation mode nonzero counters wrap and overflow flags record it; the error total has no flag, so its wrap goes unrecorded
module pbist_top
  import pbist_pkg::*;
(
  // clock and reset
  input  wire logic            aclk,
  input  wire logic            aresetn,
  // register bus
  input  wire pbist_axil_req_t axi_req,
  output var  pbist_axil_rsp_t axi_rsp,
  // generated nibble stream
  output var  pbist_tx_t       tx,
  // received byte stream
  input  wire pbist_rx_t       rx
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  pbist_axil_rsp_t rsp_q;
  pbist_axil_rsp_t rsp_d;
  logic            aw_full_q;
  logic            aw_full_d;
  logic [7:0]      aw_idx_q;
  logic            w_full_q;
  logic            w_full_d;
  logic [31:0]     wdata_q;
  logic [3:0]      wstrb_q;
  logic [15:0]     generated_frame_length_q;
  logic [7:0]      interframe_gap_setting_q;
  logic [1:0]      ctrl_q;
  logic            lock_q;
  logic            clr_q;
  logic [15:0]     byte_snap_q;
  logic [7:0]      err_snap_q;

  logic            aw_hs;
  logic            w_hs;
  logic            ar_hs;
  logic            do_wr;
  logic            bvalid_d;
  logic            rvalid_d;
  logic            wr_hit;
  logic            wr_status;
  logic [7:0]      rd_idx;
  logic            rd_hit;
  logic [31:0]     rd_data;
  logic [31:0]     status_word;

  logic [15:0]     byte_cnt;
  logic [7:0]      err_cnt;
  logic            byte_ovf;
  logic            pkt_ovf;

  // ---------------------------------------------------------------------------
  // bus handshakes and decode
  // ---------------------------------------------------------------------------
  assign axi_rsp   = rsp_q;
  assign aw_hs     = axi_req.awvalid & rsp_q.awready;
  assign w_hs      = axi_req.wvalid & rsp_q.wready;
  assign ar_hs     = axi_req.arvalid & rsp_q.arready;
  // address and data may land in either order; write fires once both are held
  assign do_wr     = aw_full_q & w_full_q & ~rsp_q.bvalid;
  assign aw_full_d = (aw_full_q | aw_hs) & ~do_wr;
  assign w_full_d  = (w_full_q | w_hs) & ~do_wr;
  assign bvalid_d  = do_wr | (rsp_q.bvalid & ~axi_req.bready);
  assign rvalid_d  = ar_hs | (rsp_q.rvalid & ~axi_req.rready);

  assign wr_status = (aw_idx_q == IDX_STATUS);
  assign wr_hit    = wr_status | (aw_idx_q == IDX_BYTE_TOTAL) | (aw_idx_q == IDX_PKT_LEN)
                   | (aw_idx_q == IDX_PKT_GAP) | (aw_idx_q == IDX_CONTROL);

  assign rd_idx    = reg_index(axi_req.araddr);
  assign rd_hit    = (rd_idx == IDX_STATUS) | (rd_idx == IDX_BYTE_TOTAL) | (rd_idx == IDX_PKT_LEN)
                   | (rd_idx == IDX_PKT_GAP) | (rd_idx == IDX_CONTROL);

  // flags are live, counts come from the snapshot
  assign status_word = {21'h000000, pkt_ovf, byte_ovf, 1'b0, err_snap_q}; // [R08] [R09]

  assign rd_data = (rd_idx == IDX_BYTE_TOTAL) ? {16'h0000, byte_snap_q} : // [R03]
                   (rd_idx == IDX_STATUS)     ? status_word :
                   (rd_idx == IDX_PKT_LEN)    ? {16'h0000, generated_frame_length_q} :
                   (rd_idx == IDX_PKT_GAP)    ? {24'h000000, interframe_gap_setting_q} :
                   (rd_idx == IDX_CONTROL)    ? {30'h00000000, ctrl_q} :
                                                32'h00000000;

  always_comb begin
    rsp_d         = rsp_q;
    rsp_d.bvalid  = bvalid_d;
    rsp_d.rvalid  = rvalid_d;
    rsp_d.awready = ~aw_full_d & ~bvalid_d;
    rsp_d.wready  = ~w_full_d & ~bvalid_d;
    rsp_d.arready = ~rvalid_d;
    if (do_wr) begin
      rsp_d.bresp = wr_hit ? RESP_OKAY : RESP_SLVERR;
    end
    if (ar_hs) begin
      rsp_d.rdata = rd_data;
      rsp_d.rresp = rd_hit ? RESP_OKAY : RESP_SLVERR;
    end
  end

  // ---------------------------------------------------------------------------
  // bus state
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rsp_q     <= '0;
      aw_full_q <= 1'b0;
      w_full_q  <= 1'b0;
      aw_idx_q  <= IDX_NONE;
      wdata_q   <= 32'h00000000;
      wstrb_q   <= 4'h0;
    end else begin
      rsp_q     <= rsp_d;
      aw_full_q <= aw_full_d;
      w_full_q  <= w_full_d;
      if (aw_hs) begin
        aw_idx_q <= reg_index(axi_req.awaddr);
      end
      if (w_hs) begin
        wdata_q <= axi_req.wdata;
        wstrb_q <= axi_req.wstrb;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // settings registers
  // ---------------------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      generated_frame_length_q <= LEN_RST; // [R10]
      interframe_gap_setting_q <= GAP_RST; // [R12]
      ctrl_q                   <= CTRL_RST;
    end else if (do_wr) begin
      if (aw_idx_q == IDX_PKT_LEN && wstrb_q[0]) begin
        generated_frame_length_q[7:0] <= wdata_q[7:0];
      end
      if (aw_idx_q == IDX_PKT_LEN && wstrb_q[1]) begin
        generated_frame_length_q[15:8] <= wdata_q[15:8];
      end
      if (aw_idx_q == IDX_PKT_GAP && wstrb_q[0]) begin
        interframe_gap_setting_q <= wdata_q[7:0];
      end
      if (aw_idx_q == IDX_CONTROL && wstrb_q[0]) begin
        ctrl_q <= wdata_q[1:0];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // lock and snapshot
  // ---------------------------------------------------------------------------
  // snapshot and clear share one edge, so the cleared epoch is never lost
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lock_q      <= 1'b0;
      clr_q       <= 1'b0;
      byte_snap_q <= 16'h0000;
      err_snap_q  <= 8'h00;
    end else begin
      lock_q <= do_wr & wr_status & wstrb_q[0] & wdata_q[ST_LOCK];       // [R06]
      clr_q  <= do_wr & wr_status & wstrb_q[0] & wdata_q[ST_LOCK_CLEAR]; // [R07]
      if (lock_q || clr_q) begin // [R03] [R06]
        byte_snap_q <= byte_cnt;
        err_snap_q  <= err_cnt;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // generator and checker
  // ---------------------------------------------------------------------------
  pbist_frame_gen i_pbist_frame_gen (
    .aclk                   (aclk),
    .aresetn                (aresetn),
    .enable                 (ctrl_q[CTRL_GEN_EN]),
    .generated_frame_length (generated_frame_length_q),
    .interframe_gap_setting (interframe_gap_setting_q),
    .tx_q                   (tx)
  );

  pbist_checker i_pbist_checker (
    .aclk                          (aclk),
    .aresetn                       (aresetn),
    .rx                            (rx),
    .counter_saturation_mode       (ctrl_q[CTRL_MODE]),
    .clr                           (clr_q),
    .checker_received_byte_total_q (byte_cnt),
    .checker_error_byte_total_q    (err_cnt),
    .byte_counter_wrapped_flag_q   (byte_ovf),
    .packet_counter_wrapped_flag_q (pkt_ovf)
  );

  // ---------------------------------------------------------------------------
  // stream monitors for checks
  // ---------------------------------------------------------------------------
  logic [16:0] frame_nib_q;
  logic [16:0] gap_nib_q;
  logic [15:0] len_mon_q;
  logic [7:0]  gap_mon_q;
  logic        gap_armed_q;
  logic        tx_rise;

  assign tx_rise = tx.valid & (frame_nib_q == 17'h00000);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      frame_nib_q <= 17'h00000;
      gap_nib_q   <= 17'h00000;
      len_mon_q   <= LEN_RST;
      gap_mon_q   <= GAP_RST;
      gap_armed_q <= 1'b0;
    end else begin
      frame_nib_q <= tx.valid ? frame_nib_q + 17'h00001 : 17'h00000;
      gap_nib_q   <= tx.valid ? 17'h00000 : gap_nib_q + 17'h00001;
      if (tx_rise) begin
        len_mon_q <= generated_frame_length_q;
        gap_mon_q <= interframe_gap_setting_q;
      end
      // gap length is only exact while the generator stays enabled
      if (!ctrl_q[CTRL_GEN_EN]) begin
        gap_armed_q <= 1'b0;
      end else if (tx.valid) begin
        gap_armed_q <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_snap_byte;
    (lock_q || clr_q) |=> byte_snap_q == $past(byte_cnt);
  endproperty
  a_snap_byte: assert property (p_snap_byte) else $error("byte snapshot mismatch"); // [R03]

  property p_snap_err;
    (lock_q || clr_q) |=> err_snap_q == $past(err_cnt);
  endproperty
  a_snap_err: assert property (p_snap_err) else $error("error snapshot mismatch"); // [R06]

  property p_lock_pulse;
    do_wr && wr_status && wstrb_q[0] && wdata_q[ST_LOCK] |=> lock_q ##1 !lock_q;
  endproperty
  a_lock_pulse: assert property (p_lock_pulse) else $error("lock pulse missing"); // [R06]

  property p_byte_sat;
    !ctrl_q[CTRL_MODE] && byte_cnt == 16'hFFFF && !clr_q |=> byte_cnt == 16'hFFFF;
  endproperty
  a_byte_sat: assert property (p_byte_sat) else $error("byte total left saturation"); // [R02]

  property p_err_sat;
    !ctrl_q[CTRL_MODE] && err_cnt == 8'hFF && !clr_q |=> err_cnt == 8'hFF;
  endproperty
  a_err_sat: assert property (p_err_sat) else $error("error total left saturation"); // [R05]

  property p_byte_wrap;
    ctrl_q[CTRL_MODE] && byte_cnt == 16'hFFFF && !clr_q ##1 byte_cnt != 16'hFFFF
      |-> byte_cnt == 16'h0000 && byte_ovf;
  endproperty
  a_byte_wrap: assert property (p_byte_wrap) else $error("byte wrap not flagged"); // [R14]

  property p_lock_clear;
    clr_q |=> !byte_ovf && !pkt_ovf && byte_cnt <= 16'h0001 && err_cnt <= 8'h01;
  endproperty
  a_lock_clear: assert property (p_lock_clear) else $error("lock-and-clear left state"); // [R07]

  property p_pkt_ovf_hold;
    pkt_ovf && !clr_q |=> pkt_ovf;
  endproperty
  a_pkt_ovf_hold: assert property (p_pkt_ovf_hold) else $error("packet overflow flag dropped"); // [R08]

  property p_byte_ovf_hold;
    byte_ovf && !clr_q |=> byte_ovf;
  endproperty
  a_byte_ovf_hold: assert property (p_byte_ovf_hold) else $error("byte overflow flag dropped"); // [R09]

  property p_frame_len;
    $fell(tx.valid) && gap_mon_q != 8'h00 |-> $past(frame_nib_q) == FRAME_OVERHEAD + {len_mon_q, 1'b0} - 17'h00001;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong"); // [R10]

  property p_preamble;
    tx.valid && gap_mon_q != 8'h00 && frame_nib_q < 17'(PRE_NIBBLES) |-> tx.nibble == PRE_NIBBLE;
  endproperty
  a_preamble: assert property (p_preamble) else $error("preamble nibble wrong"); // [R11]

  property p_sfd;
    tx.valid && gap_mon_q != 8'h00 && frame_nib_q == 17'(PRE_NIBBLES)
      |-> tx.nibble == SFD_BYTE[3:0] ##1 tx.nibble == SFD_BYTE[7:4];
  endproperty
  a_sfd: assert property (p_sfd) else $error("delimiter wrong"); // [R11]

  property p_gap;
    tx_rise && gap_armed_q && gap_mon_q != 8'h00 |-> gap_nib_q == 17'({gap_mon_q, 3'b000});
  endproperty
  a_gap: assert property (p_gap) else $error("gap length wrong"); // [R12]

  property p_bvalid_hold;
    rsp_q.bvalid && !axi_req.bready |=> rsp_q.bvalid;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("write response dropped");

  property p_rvalid_hold;
    rsp_q.rvalid && !axi_req.rready |=> rsp_q.rvalid && $stable(rsp_q.rdata);
  endproperty
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("read data dropped");

  property p_clr_pulse;
    do_wr && wr_status && wstrb_q[0] && wdata_q[ST_LOCK_CLEAR] |=> clr_q ##1 !clr_q;
  endproperty
  a_clr_pulse: assert property (p_clr_pulse) else $error("lock-and-clear pulse missing"); // [R07]

  property p_byte_count;
    rx.valid && byte_cnt != 16'hFFFF && !clr_q |=> byte_cnt == $past(byte_cnt) + 16'h0001;
  endproperty
  a_byte_count: assert property (p_byte_count) else $error("byte total missed a byte"); // [R01]

  property p_err_quiet;
    !rx.valid && !clr_q |=> err_cnt == $past(err_cnt);
  endproperty
  a_err_quiet: assert property (p_err_quiet) else $error("error total moved without a byte"); // [R04]

endmodule : pbist_top
`default_nettype wire

/* File: logic/pbist_pkg.sv */
`default_nettype none
package pbist_pkg;

  // ---------------------------------------------------------------------------
  // register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [7:0]  IDX_BYTE_TOTAL = 8'h71;
  localparam logic [7:0]  IDX_STATUS     = 8'h72;
  localparam logic [7:0]  IDX_PKT_LEN    = 8'h7B;
  localparam logic [7:0]  IDX_PKT_GAP    = 8'h7C;
  localparam logic [7:0]  IDX_CONTROL    = 8'h16;
  localparam logic [7:0]  IDX_NONE       = 8'hFF;

  // ---------------------------------------------------------------------------
  // field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned ST_LOCK        = 0;
  localparam int unsigned ST_LOCK_CLEAR  = 1;
  localparam int unsigned ST_BYTE_OVF    = 9;
  localparam int unsigned ST_PKT_OVF     = 10;
  localparam int unsigned CTRL_MODE      = 0;
  localparam int unsigned CTRL_GEN_EN    = 1;
  localparam logic [15:0] LEN_RST        = 16'h05DC;
  localparam logic [7:0]  GAP_RST        = 8'h7D;
  localparam logic [1:0]  CTRL_RST       = 2'h0;

  // ---------------------------------------------------------------------------
  // frame layout and pattern
  // ---------------------------------------------------------------------------
  localparam logic [4:0]  PRE_NIBBLES    = 5'h0D;
  localparam logic [3:0]  PRE_NIBBLE     = 4'h5;
  localparam logic [7:0]  SFD_BYTE       = 8'hD5;
  localparam logic [16:0] FRAME_OVERHEAD = 17'h0000F;
  localparam int unsigned GAP_SHIFT      = 3;
  localparam logic [14:0] PRBS_SEED      = 15'h7FFF;
  localparam logic [1:0]  WARM_BYTES     = 2'h2;
  localparam logic [1:0]  RESP_OKAY      = 2'h0;
  localparam logic [1:0]  RESP_SLVERR    = 2'h2;

  // ---------------------------------------------------------------------------
  // carriers
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic        awvalid;
    logic [11:0] awaddr;
    logic        wvalid;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bready;
    logic        arvalid;
    logic [11:0] araddr;
    logic        rready;
  } pbist_axil_req_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pbist_axil_rsp_t;

  typedef struct packed {
    logic       valid;
    logic [3:0] nibble;
  } pbist_tx_t;

  typedef struct packed {
    logic       valid;
    logic       last;
    logic [7:0] data;
  } pbist_rx_t;

  // eight steps of x^15 + x^14 + 1; the low byte is the next pattern byte
  function automatic logic [14:0] prbs_step(input logic [14:0] s);
    logic [14:0] v;
    v = s;
    for (int i = 0; i < 8; i++) begin
      v = {v[13:0], v[14] ^ v[13]};
    end
    return v;
  endfunction : prbs_step

  function automatic logic [7:0] reg_index(input logic [11:0] addr);
    return (addr[11:10] == 2'h0) ? addr[9:2] : IDX_NONE;
  endfunction : reg_index

endpackage : pbist_pkg
`default_nettype wire

/* File: logic/pbist_frame_gen.sv */
`timescale 1ns/1ps
`default_nettype none
module pbist_frame_gen
  import pbist_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // settings
  input  wire logic        enable,
  input  wire logic [15:0] generated_frame_length,
  input  wire logic [7:0]  interframe_gap_setting,
  // nibble stream
  output var  pbist_tx_t   tx_q
);

  typedef enum logic [2:0] {G_IDLE, G_PRE, G_SFD, G_PAY, G_GAP} pbist_gen_state_t;

  pbist_gen_state_t state_q;
  logic [16:0]      cnt_q;
  logic [15:0]      len_q;
  logic [7:0]       gap_q;
  logic [14:0]      lfsr_q;
  logic [16:0]      pay_last;
  logic [16:0]      gap_last;

  assign pay_last = {len_q, 1'b0} - 17'h00001;
  assign gap_last = 17'({gap_q, 3'b000}) - 17'h00001;

  // settings are latched per frame so a write mid-frame cannot tear it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_q <= G_IDLE;
      cnt_q   <= 17'h00000;
      len_q   <= LEN_RST;
      gap_q   <= GAP_RST;
      lfsr_q  <= PRBS_SEED;
      tx_q    <= '0;
    end else begin
      cnt_q <= cnt_q + 17'h00001;
      case (state_q)
        G_IDLE: begin
          tx_q  <= '0;
          cnt_q <= 17'h00000;
          if (enable) begin
            state_q <= G_PRE;
            len_q   <= generated_frame_length;
            gap_q   <= interframe_gap_setting;
          end
        end
        G_PRE: begin
          tx_q <= '{valid: 1'b1, nibble: PRE_NIBBLE}; // [R11]
          if (cnt_q == 17'(PRE_NIBBLES - 5'h01)) begin
            state_q <= G_SFD;
            cnt_q   <= 17'h00000;
          end
        end
        G_SFD: begin
          tx_q <= '{valid: 1'b1, nibble: cnt_q[0] ? SFD_BYTE[7:4] : SFD_BYTE[3:0]}; // [R11]
          if (cnt_q[0]) begin
            state_q <= (len_q == 16'h0000) ? G_GAP : G_PAY;
            cnt_q   <= 17'h00000;
          end
        end
        G_PAY: begin
          tx_q <= '{valid: 1'b1, nibble: cnt_q[0] ? lfsr_q[7:4] : lfsr_q[3:0]};
          if (cnt_q[0]) begin
            lfsr_q <= prbs_step(lfsr_q);
          end
          if (cnt_q == pay_last) begin // [R10]
            state_q <= G_GAP;
            cnt_q   <= 17'h00000;
          end
        end
        G_GAP: begin
          tx_q <= '0;
          // zero gap still costs the idle cycle it takes to decide
          if (gap_q == 8'h00 || cnt_q == gap_last) begin // [R12]
            state_q <= enable ? G_PRE : G_IDLE;
            cnt_q   <= 17'h00000;
            len_q   <= generated_frame_length;
            gap_q   <= interframe_gap_setting;
          end
        end
        default: begin
          state_q <= G_IDLE;
          tx_q    <= '0;
        end
      endcase
    end
  end

endmodule : pbist_frame_gen
`default_nettype wire

/* File: logic/pbist_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module pbist_checker
  import pbist_pkg::*;
(
  // clock and reset
  input  wire logic      aclk,
  input  wire logic      aresetn,
  // byte stream under check
  input  wire pbist_rx_t rx,
  // control
  input  wire logic      counter_saturation_mode,
  input  wire logic      clr,
  // live counts and flags
  output logic [15:0]    checker_received_byte_total_q,
  output logic [7:0]     checker_error_byte_total_q,
  output logic           byte_counter_wrapped_flag_q,
  output logic           packet_counter_wrapped_flag_q
);

  logic [14:0] hist_q;
  logic [1:0]  warm_q;
  logic [15:0] pkt_cnt_q;
  logic [14:0] expect_st;
  logic        bad;
  logic        pkt_inc;
  logic        byte_max;
  logic        err_max;
  logic        pkt_max;
  logic        wrap;

  // self-synchronising: history is refilled from what arrives
  assign expect_st = prbs_step(hist_q);
  assign bad       = rx.valid & (warm_q == WARM_BYTES) & (rx.data != expect_st[7:0]);
  assign pkt_inc   = rx.valid & rx.last;
  assign byte_max  = &checker_received_byte_total_q;
  assign err_max   = &checker_error_byte_total_q;
  assign pkt_max   = &pkt_cnt_q;
  assign wrap      = counter_saturation_mode;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hist_q <= PRBS_SEED;
      warm_q <= 2'h0;
    end else if (rx.valid) begin
      hist_q <= {hist_q[6:0], rx.data};
      warm_q <= rx.last ? 2'h0 : ((warm_q == WARM_BYTES) ? warm_q : warm_q + 2'h1);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || clr) begin
      checker_received_byte_total_q <= (!aresetn) ? 16'h0000 : {15'h0000, rx.valid}; // [R07]
      checker_error_byte_total_q    <= (!aresetn) ? 8'h00 : {7'h00, bad};
      pkt_cnt_q                     <= (!aresetn) ? 16'h0000 : {15'h0000, pkt_inc};
      byte_counter_wrapped_flag_q   <= 1'b0;
      packet_counter_wrapped_flag_q <= 1'b0;
    end else begin
      if (rx.valid && (wrap || !byte_max)) begin // [R01] [R02] [R14]
        checker_received_byte_total_q <= checker_received_byte_total_q + 16'h0001;
      end
      if (bad && (wrap || !err_max)) begin // [R04] [R05] [R14]
        checker_error_byte_total_q <= checker_error_byte_total_q + 8'h01;
      end
      if (pkt_inc && (wrap || !pkt_max)) begin
        pkt_cnt_q <= pkt_cnt_q + 16'h0001;
      end
      if (rx.valid && byte_max) begin // [R09]
        byte_counter_wrapped_flag_q <= 1'b1;
      end
      if (pkt_inc && pkt_max) begin // [R08]
        packet_counter_wrapped_flag_q <= 1'b1;
      end
    end
  end

endmodule : pbist_checker
`default_nettype wire

/* File: sim/pbist_loop_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// loopback: transmit nibbles back as bytes
// ----------------------------------------
module pbist_loop_model
  import pbist_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // streams
  input  wire pbist_tx_t  tx,
  input  wire logic [7:0] err_mask,
  output var  pbist_rx_t  rx
);
  logic       pay_q;
  logic       hi_q;
  logic       pend_q;
  logic [3:0] lo_q;
  logic [7:0] byte_q;
  // last byte is only known a cycle late; error mask hits that byte alone
  assign rx = '{pend_q, pend_q & ~tx.valid,
                pend_q ? byte_q ^ ({8{~tx.valid}} & err_mask) : ~byte_q};
  always_ff @(posedge aclk) begin
    pend_q <= 1'b0;
    if (!aresetn | !tx.valid) begin
      pay_q  <= 1'b0;
      hi_q   <= 1'b0;
      byte_q <= aresetn ? byte_q : 8'h00;
    end else if (!pay_q) begin
      pay_q <= (tx.nibble == 4'hD);
    end else if (!hi_q) begin
      lo_q <= tx.nibble;
      hi_q <= 1'b1;
    end else begin
      byte_q <= {tx.nibble, lo_q};
      pend_q <= 1'b1;
      hi_q   <= 1'b0;
    end
  end
endmodule : pbist_loop_model
`default_nettype wire

/* File: sim/tb_pbist_top.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin samples_checked++; if ((g) !== (e)) begin failures++; \
  $display("ERROR %s expected %0h seen %0h", n, e, g); end end
module tb_pbist_top;
  import pbist_pkg::*;
  localparam logic [11:0] A_BT = {2'h0, IDX_BYTE_TOTAL, 2'h0};
  localparam logic [11:0] A_ST = {2'h0, IDX_STATUS, 2'h0};
  localparam logic [11:0] A_LN = {2'h0, IDX_PKT_LEN, 2'h0};
  localparam logic [11:0] A_GP = {2'h0, IDX_PKT_GAP, 2'h0};
  localparam logic [11:0] A_CT = {2'h0, IDX_CONTROL, 2'h0};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic use_tb = 1'b0;
  logic [7:0] err_mask = 8'h00;
  pbist_axil_req_t req = '0;
  pbist_axil_rsp_t rsp;
  pbist_tx_t tx;
  pbist_rx_t rx, loop_rx, tb_rx;
  int failures = 0;
  int samples_checked = 0;
  int run = 0;
  int idle = 0;
  int seen = 0;
  logic [31:0] d;
  logic [1:0] r;
  initial tb_rx = '0;
  always #10 aclk = ~aclk;
  assign rx = use_tb ? tb_rx : loop_rx;
  pbist_top i_pbist_top (.aclk(aclk), .aresetn(aresetn), .axi_req(req), .axi_rsp(rsp), .tx(tx), .rx(rx));
  pbist_loop_model i_pbist_loop_model (.aclk(aclk), .aresetn(aresetn), .tx(tx), .err_mask(err_mask),
                                       .rx(loop_rx));
  // ------------------------------
  // frame shape on the nibble link
  // ------------------------------
  always @(negedge aclk) begin
    if (tx.valid === 1'b1) begin
      if (run < 14) `CHK("preamble", 4'h5, tx.nibble)
      if (run == 14) `CHK("sfd", 4'hD, tx.nibble)
      if (run == 0 && seen) `CHK("gap", 8 * 16, idle)
      run++;
      idle = 0;
    end else begin
      if (run > 0) `CHK("frame", 15 + 2 * 4, run)
      seen = seen | (run > 0);
      run = 0;
      idle++;
    end
  end
  // ---------
  // bus tasks
  // ---------
  task automatic wr(input logic [11:0] a, input logic [31:0] v);
    logic b, ao, wo;
    b = 1'b0;
    @(posedge aclk);
    req.awvalid <= 1'b1; req.awaddr <= a; req.wvalid <= 1'b1; req.wdata <= v; req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    while (!b) begin
      @(negedge aclk);
      {b, ao, wo, r} = {rsp.bvalid, rsp.awready, rsp.wready, rsp.bresp};
      @(posedge aclk);
      if (ao) req.awvalid <= 1'b0;
      if (wo) req.wvalid <= 1'b0;
      if (b) req.bready <= 1'b0;
    end
  endtask : wr
  task automatic rd(input logic [11:0] a);
    logic g, k;
    g = 1'b0;
    @(posedge aclk);
    req.arvalid <= 1'b1; req.araddr <= a; req.rready <= 1'b1;
    while (!g) begin
      @(negedge aclk);
      {g, k, d, r} = {rsp.rvalid, rsp.arready, rsp.rdata, rsp.rresp};
      @(posedge aclk);
      if (k) req.arvalid <= 1'b0;
      if (g) req.rready <= 1'b0;
    end
  endtask : rd
  task automatic frame_end();
    @(posedge tx.valid);
    @(negedge tx.valid);
    @(posedge aclk);
  endtask : frame_end
  // feeding bytes straight in lets the counters reach their limits quickly
  task automatic push(input int n, input logic l);
    for (int i = 0; i < n; i++) begin
      @(posedge aclk);
      tb_rx <= '{1'b1, l, i[7:0] ^ 8'h5A};
    end
    @(posedge aclk);
    tb_rx <= '{1'b0, 1'b0, 8'hA5};
  endtask : push
  task automatic final_report();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report
  initial begin
    #1_600_000;
    failures++;
    final_report();
  end
  // -----
  // tests
  // -----
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(A_LN); `CHK("len_rst", 32'h05DC, d)
    rd(A_GP); `CHK("gap_rst", 32'h7D, d)
    rd(12'hC00); `CHK("unmapped", RESP_SLVERR, r)
    wr(12'hC00, 32'h0); `CHK("wr_unmapped", RESP_SLVERR, r)
    $display("test reset done");
    wr(A_LN, 32'h4);
    wr(A_GP, 32'h10);
    wr(A_CT, 32'h2);
    frame_end();
    wr(A_ST, 32'h2);
    rd(A_CT); `CHK("ctrl", 32'h2, d)
    frame_end();
    err_mask <= 8'h01;
    frame_end();
    err_mask <= 8'h00;
    frame_end();
    // three whole frames of four bytes fall after the clear
    wr(A_ST, 32'h1);
    rd(A_BT); `CHK("bytes", 32'hC, d)
    rd(A_ST); `CHK("errors", 32'h1, d)
    frame_end();
    rd(A_BT); `CHK("frozen", 32'hC, d)
    wr(A_CT, 32'h0);
    $display("test loopback done");
    use_tb <= 1'b1;
    wr(A_ST, 32'h2);
    push(65535, 1'b1);
    wr(A_ST, 32'h1);
    rd(A_BT); `CHK("max", 32'hFFFF, d)
    rd(A_ST); `CHK("no_ovf", 32'h0, d)
    push(1, 1'b1);
    wr(A_ST, 32'h1);
    rd(A_BT); `CHK("sat", 32'hFFFF, d)
    rd(A_ST); `CHK("ovf", 32'h600, d)
    wr(A_CT, 32'h1);
    push(1, 1'b1);
    wr(A_ST, 32'h1);
    rd(A_BT); `CHK("wrap", 32'h0, d)
    rd(A_ST); `CHK("wrap_ovf", 32'h600, d)
    wr(A_CT, 32'h0);
    wr(A_ST, 32'h2);
    rd(A_ST); `CHK("clr", 32'h0, d)
    push(300, 1'b0);
    wr(A_ST, 32'h1);
    rd(A_ST); `CHK("err_sat", 32'hFF, d)
    $display("test saturation done");
    final_report();
  end
endmodule : tb_pbist_top
`default_nettype wire
